// ---- dv/fps_flash_model.sv ----
`timescale 1ns/100ps
module fps_flash_model (
  input wire logic [fps_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fps_pkg::DATA_W-1:0] data_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic supply_i,
  input wire logic stuck_i,
  output logic [fps_pkg::DATA_W-1:0] data_o
);
  logic [7:0] mem [4];
  logic [7:0] pd, rd;
  logic [7:0] last = 8'h00;
  logic [1:0] la, pa, ea;
  int mode = 0, pulses = 0, erases = 0, verifies = 0, aborts = 0, bad = 0;
  realtime t0, pulse_ns;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  ////////////////////////////////////////
  always @(negedge we_n_i) if (!ce_n_i) la = addr_i[1:0];
  always @(posedge we_n_i) if (!ce_n_i)
  begin
    if (!supply_i)
      mode = 0;
    else if (mode == 2)
    begin
      if (data_i !== 8'hC0) bad++;
      if (!stuck_i) mem[pa] = mem[pa] & pd;
      pulses++;
      pulse_ns = $realtime - t0;
      mode = 3;
    end
    else if (mode == 5)
    begin
      if (data_i !== 8'hA0) bad++;
      // Slow erase, one more byte per pulse, so resuming is visible
      for (int i = 0; i <= erases && i < 4; i++) mem[i] = 8'hFF;
      erases++;
      verifies++;
      ea = la;
      mode = 6;
    end
    else if (mode == 1 && data_i !== 8'hFF)
    begin
      pa = la;
      pd = data_i;
      t0 = $realtime;
      mode = 2;
    end
    else if (mode == 4 && data_i === 8'h20) mode = 5;
    else if (data_i === 8'hFF)
    begin
      aborts += (mode == 7);
      mode = (mode == 7) ? 8 : 7;
    end
    else if (data_i === 8'h40) mode = 1;
    else if (data_i === 8'h20) mode = 4;
    else if (data_i === 8'h00) mode = 0;
    else if (data_i === 8'hA0 && mode == 6)
    begin
      ea = la;
      verifies++;
    end
    else bad++; // Verify out of turn or unknown code
  end
  always_comb rd = (mode == 3) ? mem[pa] : (mode == 6) ? mem[ea] : mem[addr_i[1:0]];
  always @(posedge oe_n_i) last = rd;
  // Released bus never repeats the last byte
  assign data_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
endmodule : fps_flash_model

// ---- dv/fps_host_props.sv ----
`timescale 1ns/100ps
module fps_host_props (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [fps_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [fps_pkg::DATA_W-1:0] mem_data_o,
  input wire logic mem_data_oe_o,
  input wire logic mem_ce_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_oe_n_o,
  input wire logic program_supply_high_level_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////
  sequence s_we_low;
    (!mem_we_n_o) [*4] ##1 mem_we_n_o;
  endsequence
  property p_we_pulse;
    $fell(mem_we_n_o) |-> s_we_low;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe width");
  property p_we_in_ce;
    !mem_we_n_o |-> !mem_ce_n_o && mem_data_oe_o && mem_oe_n_o;
  endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("strobe outside cycle");
  property p_addr_hold;
    !mem_we_n_o |=> $stable(mem_addr_o) && $stable(mem_data_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("bus moved under strobe");
  property p_supply_write;
    !mem_we_n_o |-> program_supply_high_level_o;
  endproperty
  a_supply_write: assert property (p_supply_write) else $error("write at low supply");
  property p_ramp;
    $rose(program_supply_high_level_o) |-> mem_ce_n_o [*4];
  endproperty
  a_ramp: assert property (p_ramp) else $error("no ramp wait");
  property p_done;
    done_o |-> !program_supply_high_level_o ##1 !done_o;
  endproperty
  a_done: assert property (p_done) else $error("done with supply high");
  property p_idle;
    !busy_o |-> mem_ce_n_o && mem_we_n_o && mem_oe_n_o && !mem_data_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("bus active while idle");
  property p_start;
    start_i && !busy_o |=> busy_o;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_read;
    !mem_oe_n_o |-> !mem_data_oe_o && mem_we_n_o && !mem_ce_n_o;
  endproperty
  a_read: assert property (p_read) else $error("read while driving");
endmodule : fps_host_props

bind fps_host fps_host_props u_props (
  .clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i),
  .start_i(start_i),
  .busy_o(busy_o),
  .done_o(done_o),
  .mem_addr_o(mem_addr_o),
  .mem_data_o(mem_data_o),
  .mem_data_oe_o(mem_data_oe_o),
  .mem_ce_n_o(mem_ce_n_o),
  .mem_we_n_o(mem_we_n_o),
  .mem_oe_n_o(mem_oe_n_o),
  .program_supply_high_level_o(program_supply_high_level_o)
);

// ---- dv/fps_host_tb.sv ----
`timescale 1ns/100ps
module fps_host_tb;
  logic clk_sys_i, sys_rst_i = 1, start_i = 0, stuck = 0;
  logic [1:0] op_i = 0;
  logic [17:0] addr_i = 0, fail_addr_o, m_a;
  logic [7:0] data_i = 0, m_q, m_d;
  logic busy_o, done_o, fail_o, skipped_o, m_oe, ce_n, we_n, oe_n, sup;
  int errors = 0, checks_done = 0, p0, e0, v0;
  // Undriven data bus floats, so a write without data enable is caught by the model
  wire [7:0] m_bus = m_oe ? m_d : 8'hZZ;
  fps_host #(.ERASE_CYC(50), .RAMP_CYC(4), .SETTLE_CYC(3), .LAST_ADDR(18'h00003)) uut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .op_i(op_i),
    .addr_i(addr_i), .data_i(data_i), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o),
    .skipped_o(skipped_o), .fail_addr_o(fail_addr_o), .mem_addr_o(m_a), .mem_data_i(m_q),
    .mem_data_o(m_d), .mem_data_oe_o(m_oe), .mem_ce_n_o(ce_n), .mem_we_n_o(we_n),
    .mem_oe_n_o(oe_n), .program_supply_high_level_o(sup));
  fps_flash_model flash (.addr_i(m_a), .data_i(m_bus), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .supply_i(sup), .stuck_i(stuck), .data_o(m_q));
  initial
  begin
    clk_sys_i = 0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic run_op(input logic [1:0] op, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i) #1;
    {op_i, addr_i, data_i, start_i} = {op, a, d, 1'b1};
    @(posedge clk_sys_i) #1;
    start_i = 0;
    chk(busy_o, 1);
    chk(sup, 1);
    // A second start while busy must be ignored
    @(posedge clk_sys_i) #1;
    start_i = 1;
    op_i = ~op;
    @(posedge clk_sys_i) #1;
    start_i = 0;
    while (done_o !== 1'b1 && n < 60000)
    begin
      @(posedge clk_sys_i) #1;
      n++;
    end
    chk(done_o, 1);
    chk(busy_o, 0);
    chk(sup, 0);
    chk(flash.mode, 0);
    chk(flash.bad, 0);
  endtask : run_op
  ////////////////////////////////////////
  task automatic t_prog;
    p0 = flash.pulses;
    run_op(fps_pkg::OP_PROGRAM, 2, 8'h5A);
    run_op(fps_pkg::OP_PROGRAM, 0, 8'h3C);
    chk(flash.mem[2], 8'h5A);
    chk(flash.mem[0], 8'h3C);
    chk(flash.pulses - p0, 2);
    chk(fail_o, 0);
    chk(flash.pulse_ns >= 10000.0, 1);
    $display("prog done");
  endtask : t_prog
  task automatic t_fail;
    stuck = 1;
    p0 = flash.pulses;
    run_op(fps_pkg::OP_PROGRAM, 1, 8'h00);
    stuck = 0;
    chk(fail_o, 1);
    chk(fail_addr_o, 1);
    chk(flash.pulses - p0, 25);
    $display("fail done");
  endtask : t_fail
  task automatic t_abort;
    run_op(fps_pkg::OP_ABORT, 0, 0);
    chk(flash.aborts, 1);
    chk(flash.mem[2], 8'h5A);
    $display("abort done");
  endtask : t_abort
  task automatic t_erase;
    run_op(fps_pkg::OP_PRECLEAR, 0, 0);
    for (int i = 0; i < 4; i++) chk(flash.mem[i], 0);
    e0 = flash.erases;
    v0 = flash.verifies;
    run_op(fps_pkg::OP_ERASE, 0, 0);
    for (int i = 0; i < 4; i++) chk(flash.mem[i], 8'hFF);
    chk(flash.erases - e0, 4);
    chk(flash.verifies - v0, 7);
    chk(skipped_o, 0);
    run_op(fps_pkg::OP_ERASE, 0, 0);
    chk(skipped_o, 1);
    chk(flash.erases - e0, 4);
    $display("erase done");
  endtask : t_erase
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    #1 sys_rst_i = 0;
    t_prog();
    t_fail();
    t_abort();
    t_erase();
    summarize();
  end
  initial
  begin
    repeat (80000) @(posedge clk_sys_i);
    errors++;
    summarize();
  end
endmodule : fps_host_tb

// ---- hw/fps_host.sv ----
`timescale 1ns/100ps
module fps_host #(
  parameter int ERASE_CYC = fps_pkg::ERASE_PULSE_CYC,
  parameter int RAMP_CYC = fps_pkg::SUPPLY_RAMP_CYC,
  parameter int PROG_CYC = fps_pkg::PROG_PULSE_CYC,
  parameter int SETTLE_CYC = fps_pkg::VERIFY_SETTLE_CYC,
  parameter logic [fps_pkg::ADDR_W-1:0] LAST_ADDR = '1
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [1:0] op_i,
  input wire logic [fps_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fps_pkg::DATA_W-1:0] data_i,
  output logic busy_o,
  output logic done_o,
  output logic fail_o,
  output logic skipped_o,
  output logic [fps_pkg::ADDR_W-1:0] fail_addr_o,
  output logic [fps_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [fps_pkg::DATA_W-1:0] mem_data_i,
  output logic [fps_pkg::DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_o,
  output logic mem_ce_n_o,
  output logic mem_we_n_o,
  output logic mem_oe_n_o,
  output logic program_supply_high_level_o
);
  typedef enum logic [15:0] {
    S_IDLE = 16'h0001, S_RAMP = 16'h0002, S_BLANK = 16'h0004, S_PSET = 16'h0008,
    S_PWR = 16'h0010, S_PWAIT = 16'h0020, S_PVFY = 16'h0040, S_PRD = 16'h0080,
    S_ESET = 16'h0100, S_EGO = 16'h0200, S_EWAIT = 16'h0400, S_EVFY = 16'h0800,
    S_ERD = 16'h1000, S_RDCMD = 16'h2000, S_FALL = 16'h4000, S_ABORT = 16'h8000
  } fps_state_t;
  typedef enum logic [2:0] {
    B_IDLE = 3'h1, B_WR = 3'h2, B_RD = 3'h4
  } fps_bus_t;
  fps_state_t state;
  fps_bus_t bus;
  logic [1:0] op;
  logic [fps_pkg::ADDR_W-1:0] tgt_addr;
  logic [fps_pkg::DATA_W-1:0] tgt_data;
  logic [fps_pkg::ADDR_W-1:0] vfy_addr;
  logic [fps_pkg::TMR_W-1:0] tmr;
  logic [fps_pkg::TMR_W-1:0] bcnt;
  logic [9:0] pulses;
  logic two_writes;
  logic bus_go;
  logic bus_wr;
  logic bus_done;
  logic [fps_pkg::DATA_W-1:0] rd_data;
  logic [fps_pkg::DATA_W-1:0] wr_data;
  logic [fps_pkg::ADDR_W-1:0] wr_addr;
  logic timer_done;
  assign timer_done = (tmr == '0);
  assign busy_o = (state != S_IDLE);
  assign mem_ce_n_o = (bus == B_IDLE);
  assign mem_data_oe_o = (bus == B_WR);
  //////////////////////////////////////////////////////////////////////////////
  // Bus cycle engine: address and data set at cycle start, before strobe fall, held past rise
  always_ff @(posedge clk_sys_i)
  begin
    bus_done <= 1'b0;
    if (sys_rst_i)
    begin
      bus <= B_IDLE;
      bcnt <= '0;
      mem_we_n_o <= 1'b1;
      mem_oe_n_o <= 1'b1;
      mem_addr_o <= '0;
      mem_data_o <= '0;
      rd_data <= '0;
    end
    else
    begin
      unique case (bus)
        B_IDLE:
        begin
          if (bus_go)
          begin
            mem_addr_o <= wr_addr;
            mem_data_o <= wr_data;
            bcnt <= '0;
            bus <= bus_wr ? B_WR : B_RD;
          end
        end
        B_WR:
        begin
          bcnt <= bcnt + 1'b1;
          if (bcnt == fps_pkg::TMR_W'(fps_pkg::WE_SETUP_CYC))
            mem_we_n_o <= 1'b0;
          if (bcnt == fps_pkg::TMR_W'(fps_pkg::WE_SETUP_CYC + fps_pkg::WE_LOW_CYC))
            mem_we_n_o <= 1'b1;
          if (bcnt == fps_pkg::TMR_W'(fps_pkg::WE_SETUP_CYC + fps_pkg::WE_LOW_CYC
                                      + fps_pkg::WE_HOLD_CYC))
          begin
            bus <= B_IDLE;
            bus_done <= 1'b1;
          end
        end
        B_RD:
        begin
          bcnt <= bcnt + 1'b1;
          mem_oe_n_o <= 1'b0;
          if (bcnt == fps_pkg::TMR_W'(fps_pkg::RD_CYC))
          begin
            rd_data <= mem_data_i;
            mem_oe_n_o <= 1'b1;
            bus <= B_IDLE;
            bus_done <= 1'b1;
          end
        end
        default:
          bus <= B_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Bus request per state; only issued while the engine is idle
  always_comb
  begin
    bus_go = 1'b0;
    bus_wr = 1'b1;
    wr_addr = tgt_addr;
    wr_data = fps_pkg::CMD_READ;
    unique case (state)
      S_BLANK: begin bus_go = 1'b1; bus_wr = 1'b0; wr_addr = vfy_addr; end
      S_PSET: begin bus_go = 1'b1; wr_data = fps_pkg::CMD_SETUP_PROG; end
      S_PWR: begin bus_go = 1'b1; wr_data = tgt_data; end
      S_PVFY: begin bus_go = timer_done; wr_data = fps_pkg::CMD_PROG_VERIFY; end
      S_PRD: begin bus_go = timer_done; bus_wr = 1'b0; end
      S_ESET, S_EGO: begin bus_go = 1'b1; wr_data = fps_pkg::CMD_SETUP_ERASE; end
      S_EVFY:
      begin
        bus_go = timer_done;
        wr_addr = vfy_addr;
        wr_data = fps_pkg::CMD_ERASE_VERIFY;
      end
      S_ERD: begin bus_go = timer_done; bus_wr = 1'b0; wr_addr = vfy_addr; end
      S_RDCMD: begin bus_go = 1'b1; wr_data = fps_pkg::CMD_READ; end
      S_ABORT: begin bus_go = 1'b1; wr_data = fps_pkg::CMD_RESET; end
      default: bus_go = 1'b0;
    endcase
    bus_go = bus_go && (bus == B_IDLE) && !bus_done;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys_i)
  begin
    done_o <= 1'b0;
    if (sys_rst_i)
    begin
      state <= S_IDLE;
      op <= fps_pkg::OP_PROGRAM;
      tgt_addr <= '0;
      tgt_data <= '0;
      vfy_addr <= '0;
      tmr <= '0;
      pulses <= '0;
      two_writes <= 1'b0;
      fail_o <= 1'b0;
      skipped_o <= 1'b0;
      fail_addr_o <= '0;
      program_supply_high_level_o <= 1'b0;
    end
    else
    begin
      if (!timer_done)
        tmr <= tmr - 1'b1;
      unique case (state)
        S_IDLE:
          if (start_i)
          begin
            op <= op_i;
            tgt_addr <= (op_i == fps_pkg::OP_PRECLEAR) ? '0 : addr_i;
            tgt_data <= (op_i == fps_pkg::OP_PRECLEAR) ? fps_pkg::DATA_ZERO : data_i;
            vfy_addr <= '0;
            pulses <= '0;
            two_writes <= 1'b0;
            fail_o <= 1'b0;
            skipped_o <= 1'b0;
            program_supply_high_level_o <= 1'b1;
            tmr <= fps_pkg::TMR_W'(RAMP_CYC);
            state <= S_RAMP;
          end
        S_RAMP:
          if (timer_done)
          begin
            unique case (op)
              fps_pkg::OP_ERASE: state <= S_BLANK;
              fps_pkg::OP_ABORT: state <= S_ABORT;
              default: state <= S_PSET;
            endcase
          end
        S_BLANK:
          if (bus_done)
          begin
            if (rd_data != fps_pkg::DATA_ERASED)
            begin
              vfy_addr <= '0;
              state <= S_ESET;
            end
            else if (vfy_addr == LAST_ADDR)
            begin
              skipped_o <= 1'b1;
              state <= S_RDCMD;
            end
            else
              vfy_addr <= vfy_addr + 1'b1;
          end
        S_PSET:
          if (bus_done)
            state <= S_PWR;
        S_PWR:
          if (bus_done)
          begin
            pulses <= pulses + 1'b1;
            tmr <= fps_pkg::TMR_W'(PROG_CYC);
            state <= S_PVFY;
          end
        S_PVFY:
          if (bus_done)
          begin
            tmr <= fps_pkg::TMR_W'(SETTLE_CYC);
            state <= S_PRD;
          end
        S_PRD:
          if (bus_done)
          begin
            if (rd_data == tgt_data)
            begin
              pulses <= '0;
              if (op == fps_pkg::OP_PRECLEAR && tgt_addr != LAST_ADDR)
              begin
                tgt_addr <= tgt_addr + 1'b1;
                state <= S_PSET;
              end
              else
                state <= S_RDCMD;
            end
            else if (pulses == 10'(fps_pkg::MAX_PROG_PULSES))
            begin
              fail_o <= 1'b1;
              fail_addr_o <= tgt_addr;
              state <= S_RDCMD;
            end
            else
              state <= S_PSET;
          end
        S_ESET:
          if (bus_done)
            state <= S_EGO;
        S_EGO:
          if (bus_done)
          begin
            pulses <= pulses + 1'b1;
            tmr <= fps_pkg::TMR_W'(ERASE_CYC);
            state <= S_EVFY;
          end
        S_EVFY:
          if (bus_done)
          begin
            tmr <= fps_pkg::TMR_W'(SETTLE_CYC);
            state <= S_ERD;
          end
        S_ERD:
          if (bus_done)
          begin
            if (rd_data == fps_pkg::DATA_ERASED)
            begin
              if (vfy_addr == LAST_ADDR)
                state <= S_RDCMD;
              else
              begin
                vfy_addr <= vfy_addr + 1'b1;
                state <= S_EVFY;
              end
            end
            else if (pulses == 10'(fps_pkg::MAX_ERASE_PULSES))
            begin
              fail_o <= 1'b1;
              fail_addr_o <= vfy_addr;
              state <= S_RDCMD;
            end
            else
              state <= S_ESET; // Keeps vfy_addr to resume there
          end
        S_ABORT:
          if (bus_done)
          begin
            two_writes <= 1'b1;
            if (two_writes)
              state <= S_RDCMD; // Second reset write done, read command next
          end
        S_RDCMD:
          if (bus_done)
          begin
            tmr <= fps_pkg::TMR_W'(RAMP_CYC);
            state <= S_FALL;
          end
        S_FALL:
        begin
          program_supply_high_level_o <= 1'b0;
          if (timer_done)
          begin
            done_o <= 1'b1;
            state <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule : fps_host

// ---- hw/fps_pkg.sv ----
package fps_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  // Command codes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_SETUP_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_SETUP_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] DATA_ERASED = 8'hFF;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int PROG_PULSE_US = 10;
  localparam int PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int ERASE_PULSE_MS = 10;
  localparam int ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int VERIFY_SETTLE_US = 6;
  localparam int VERIFY_SETTLE_CYC = VERIFY_SETTLE_US * CLK_MHZ;
  localparam int SUPPLY_RAMP_US = 100;
  localparam int SUPPLY_RAMP_CYC = SUPPLY_RAMP_US * CLK_MHZ;
  localparam int MAX_PROG_PULSES = 25;
  localparam int MAX_ERASE_PULSES = 1000;
  // Bus cycle phases, in clocks; timer and bus counter width, in bits
  localparam int WE_SETUP_CYC = 2;
  localparam int WE_LOW_CYC = 4;
  localparam int WE_HOLD_CYC = 2;
  localparam int RD_CYC = 6;
  localparam int TMR_W = 32;
  // Operation codes on op_i
  localparam logic [1:0] OP_PROGRAM = 2'h0;
  localparam logic [1:0] OP_ERASE = 2'h1;
  localparam logic [1:0] OP_ABORT = 2'h2;
  localparam logic [1:0] OP_PRECLEAR = 2'h3;
endpackage : fps_pkg
